// >>> src/bbc_cfg.svh
// offsets, field positions, reset values and codes of the converter bank
// assumes word-addressed bus access with the index low byte on the address
`ifndef BBC_CFG_SVH
`define BBC_CFG_SVH

// register indices (byte address = 4 x index)
`define BBC_IDX_SWITCH    32'h5000_0080
`define BBC_IDX_LEVEL     32'h5000_0082
`define BBC_IDX_IDLE      32'h5000_0084
// low index byte compared against the bus word address
`define BBC_DEC_SWITCH    8'h80
`define BBC_DEC_LEVEL     8'h82
`define BBC_DEC_IDLE      8'h84

// reset values and implemented bits
`define BBC_RST_SWITCH    16'h000C
`define BBC_RST_LEVEL     16'h8C20
`define BBC_RST_IDLE      16'h0015
`define BBC_MASK_SWITCH   16'hFFFF
`define BBC_MASK_LEVEL    16'hFFFF
`define BBC_MASK_IDLE     16'h001F

// switch control fields
`define BBC_TRIM_LSB      14
`define BBC_OSW_LSB       12
`define BBC_PSW_LSB       10
`define BBC_NSW_LSB       8
`define BBC_TEST_LSB      5
`define BBC_THR_LSB       1
// level control fields
`define BBC_CORE_LSB      12
`define BBC_HIGH_LSB      9
`define BBC_TON_LSB       7
`define BBC_ILIM_LSB      3
`define BBC_CAL_LSB       0
// idle control fields
`define BBC_TMO_LSB       3
`define BBC_IDLE_LSB      1
`define BBC_AUTO_BIT      0

// low cell threshold code that never disables the boost stage
`define BBC_THR_ALWAYS    3'h7
// pin input synchroniser stages
`define BBC_SYNC_STAGES   3

`endif

// >>> src/bbc_pkg.sv
// types shared by the converter register bank
// assumes bbc_cfg.svh for all numeric constants
package bbc_pkg;

   // switch drive level
   typedef enum logic [1:0] {
      BBC_DRV_FULL,
      BBC_DRV_TWO_THIRDS,
      BBC_DRV_ONE_THIRD,
      BBC_DRV_OFF
   } bbc_drive_t;

   // trigger source of the idle voltage check
   typedef enum logic [2:0] {
      BBC_TRIG_16M,
      BBC_TRIG_4M,
      BBC_TRIG_1M,
      BBC_TRIG_250K,
      BBC_TRIG_32K
   } bbc_trig_t;

   // static controls into the analogue stage
   typedef struct packed {
      logic [1:0] sense_trim;
      bbc_drive_t output_switch_drive;
      bbc_drive_t battery_switch_drive;
      bbc_drive_t ground_switch_drive;
      logic [2:0] test_mode;
      logic [2:0] low_cell_threshold;
      logic       boost_allowed;
      logic [3:0] core_rail_setpoint;
      logic [2:0] high_rail_setpoint;
      logic [1:0] min_on_time;
      logic [3:0] switch_current_limit;
      logic [2:0] auto_calibration_ctrl;
      logic [1:0] idle_timeout;
      bbc_trig_t  idle_trigger;
      logic       step_down_on;
   } bbc_conv_t;

endpackage : bbc_pkg

// >>> src/bbc_avmm_slave.sv
// avalon-mm slave front end: one wait state, decode, registered read data
// assumes master holds the request until it sees waitrequest low
`include "bbc_cfg.svh"

module bbc_avmm_slave
   import bbc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // avalon-mm
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // register file side
   output logic      [2:0]  hit,
   input  wire logic [15:0] rd_word,
   output logic             wr_stb,
   output logic      [15:0] wr_data,
   output logic      [1:0]  wr_be
);

   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        req;

   assign req         = read | write;
   assign waitrequest = req & ~ack_r;
   assign wr_stb      = write & ack_r;
   assign wr_data     = writedata[15:0];
   assign wr_be       = byteenable[1:0];
   assign readdata    = rdata_r;

   always_comb begin
      hit[0] = (address == `BBC_DEC_SWITCH);
      hit[1] = (address == `BBC_DEC_LEVEL);
      hit[2] = (address == `BBC_DEC_IDLE);
   end

   // unmapped reads return zero since rd_word is zero with no hit
   always_comb begin
      ack_nxt   = req & ~ack_r;
      rdata_nxt = rdata_r;
      if (read && !ack_r) begin
         rdata_nxt = {16'h0000, rd_word};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r   <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

endmodule // bbc_avmm_slave

// >>> src/bbc_regs.sv
// buck/boost converter configuration bank with avalon-mm access
// assumes analogue status pins are asynchronous to clk_sys
//
// The Avalon-MM register port was left to the implementer.
`include "bbc_cfg.svh"

// Function
// - two-bit sense trim, reset zero, fed to current-sense circuit
// - three drive fields: full, two-thirds, one-third, off; reset full
// - low cell threshold reset 110; boost disabled below selected cut-off
// - core rail setpoint, reset 8, output 1.2 V plus N x 25 mV
// - high rail setpoint, reset 6, 1.8 V steps or fixed 2.4-2.76 V
// - program memory regulator on forces delivered high rail msb high
// - switch current limit, reset 4, about N x 10 mA
// - auto calibration, reset zero disables; software uses 1 or 6
// - idle trigger select, reset 10: 16 MHz, 4 MHz, 1 MHz, 250 kHz
// - without 16 MHz oscillator the idle trigger is 32 kHz
// - step-down auto enable, reset one, starts buck on grounded low cell while device active
module bbc_regs
   import bbc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // analogue and clock status, asynchronous
   input  wire logic        osc16_running,
   input  wire logic        prog_mem_reg_en,
   input  wire logic        device_active,
   input  wire logic        low_cell_grounded,
   input  wire logic        low_cell_below_cutoff,
   // controls into the converter stage
   output bbc_conv_t        conv
);

   localparam int NSYNC = 5;

   logic [2:0]  hit;
   logic [15:0] rd_word;
   logic        wr_stb;
   logic [15:0] wr_data;
   logic [1:0]  wr_be;

   bbc_avmm_slave u_bus (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .address     (address),
      .read        (read),
      .write       (write),
      .writedata   (writedata),
      .byteenable  (byteenable),
      .readdata    (readdata),
      .waitrequest (waitrequest),
      .hit         (hit),
      .rd_word     (rd_word),
      .wr_stb      (wr_stb),
      .wr_data     (wr_data),
      .wr_be       (wr_be)
   );

   // pin synchronisers: a change counts once stages two and three agree
   logic [NSYNC-1:0] in_raw;
   logic [NSYNC-1:0] filt;

   assign in_raw = {low_cell_below_cutoff, low_cell_grounded,
                    device_active, prog_mem_reg_en, osc16_running};

   genvar g;
   for (g = 0; g < NSYNC; g++) begin : g_sync
      logic [`BBC_SYNC_STAGES-1:0] sh_r;
      logic [`BBC_SYNC_STAGES-1:0] sh_nxt;
      logic                        f_r;
      logic                        f_nxt;

      always_comb begin
         sh_nxt = {sh_r[1:0], in_raw[g]};
         f_nxt  = (sh_r[1] == sh_r[2]) ? sh_r[2] : f_r;
      end

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            sh_r <= '0;
            f_r  <= 1'b0;
         end else begin
            sh_r <= sh_nxt;
            f_r  <= f_nxt;
         end
      end

      assign filt[g] = f_r;
   end

   logic osc_ok;
   logic otp_on;
   logic act_ok;
   logic gnd_ok;
   logic below_ok;

   assign osc_ok   = filt[0];
   assign otp_on   = filt[1];
   assign act_ok   = filt[2];
   assign gnd_ok   = filt[3];
   assign below_ok = filt[4];

   // register storage
   logic [15:0] sw_r;
   logic [15:0] sw_nxt;
   logic [15:0] lv_r;
   logic [15:0] lv_nxt;
   logic [15:0] id_r;
   logic [15:0] id_nxt;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] d,
                                         input logic [1:0]  be,
                                         input logic [15:0] mask);
      logic [15:0] n;
      n = old;
      if (be[0]) begin
         n[7:0] = d[7:0];
      end
      if (be[1]) begin
         n[15:8] = d[15:8];
      end
      return n & mask;
   endfunction

   // test mode and spare bits stay plain storage; software keeps them zero
   always_comb begin
      sw_nxt = sw_r;
      lv_nxt = lv_r;
      id_nxt = id_r;
      if (wr_stb && hit[0]) begin
         sw_nxt = merge(sw_r, wr_data, wr_be, `BBC_MASK_SWITCH);
      end
      if (wr_stb && hit[1]) begin
         lv_nxt = merge(lv_r, wr_data, wr_be, `BBC_MASK_LEVEL);
      end
      if (wr_stb && hit[2]) begin
         id_nxt = merge(id_r, wr_data, wr_be, `BBC_MASK_IDLE);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sw_r <= `BBC_RST_SWITCH;
         lv_r <= `BBC_RST_LEVEL;
         id_r <= `BBC_RST_IDLE;
      end else begin
         sw_r <= sw_nxt;
         lv_r <= lv_nxt;
         id_r <= id_nxt;
      end
   end

   // readback shows what software wrote, not the forced msb
   always_comb begin
      rd_word = 16'h0000;
      if (hit[0]) begin
         rd_word = sw_r;
      end
      if (hit[1]) begin
         rd_word = lv_r;
      end
      if (hit[2]) begin
         rd_word = id_r;
      end
   end

   // converter controls, registered so the analogue side sees no glitch
   bbc_conv_t  conv_r;
   bbc_conv_t  conv_nxt;
   logic [2:0] thr;
   logic [2:0] high;
   logic [1:0] idle_sel;

   always_comb begin
      thr      = sw_r[`BBC_THR_LSB +: 3];
      high     = lv_r[`BBC_HIGH_LSB +: 3];
      idle_sel = id_r[`BBC_IDLE_LSB +: 2];
      conv_nxt.sense_trim = sw_r[`BBC_TRIM_LSB +: 2];
      conv_nxt.output_switch_drive =
         bbc_drive_t'(sw_r[`BBC_OSW_LSB +: 2]);
      conv_nxt.battery_switch_drive =
         bbc_drive_t'(sw_r[`BBC_PSW_LSB +: 2]);
      conv_nxt.ground_switch_drive =
         bbc_drive_t'(sw_r[`BBC_NSW_LSB +: 2]);
      conv_nxt.test_mode = sw_r[`BBC_TEST_LSB +: 3];
      conv_nxt.low_cell_threshold = thr;
      // the comparator itself is analogue; only its verdict is gated here
      conv_nxt.boost_allowed = (thr == `BBC_THR_ALWAYS) || !below_ok;
      conv_nxt.core_rail_setpoint = lv_r[`BBC_CORE_LSB +: 4];
      conv_nxt.high_rail_setpoint = high;
      if (otp_on) begin
         conv_nxt.high_rail_setpoint[2] = 1'b1;
      end
      conv_nxt.min_on_time = lv_r[`BBC_TON_LSB +: 2];
      conv_nxt.switch_current_limit = lv_r[`BBC_ILIM_LSB +: 4];
      conv_nxt.auto_calibration_ctrl = lv_r[`BBC_CAL_LSB +: 3];
      conv_nxt.idle_timeout = id_r[`BBC_TMO_LSB +: 2];
      unique case (idle_sel)
         2'h0: conv_nxt.idle_trigger = BBC_TRIG_16M;
         2'h1: conv_nxt.idle_trigger = BBC_TRIG_4M;
         2'h2: conv_nxt.idle_trigger = BBC_TRIG_1M;
         2'h3: conv_nxt.idle_trigger = BBC_TRIG_250K;
      endcase
      if (!osc_ok) begin
         conv_nxt.idle_trigger = BBC_TRIG_32K;
      end
      conv_nxt.step_down_on =
         id_r[`BBC_AUTO_BIT] && act_ok && gnd_ok;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         conv_r <= '0;
      end else begin
         conv_r <= conv_nxt;
      end
   end

   assign conv = conv_r;

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic wr_sw;
   logic wr_lv;
   logic wr_id;

   assign wr_sw = wr_stb && hit[0];
   assign wr_lv = wr_stb && hit[1];
   assign wr_id = wr_stb && hit[2];

   a_trim_follow: assert property (
      wr_sw && wr_be[1] |-> ##2
      conv.sense_trim == $past(wr_data[`BBC_TRIM_LSB +: 2], 2))
      else $error("sense trim did not follow write");

   a_drive_follow: assert property (
      wr_sw && wr_be[1] |-> ##2
      conv.output_switch_drive == $past(wr_data[`BBC_OSW_LSB +: 2], 2)
      && conv.ground_switch_drive == $past(wr_data[`BBC_NSW_LSB +: 2], 2))
      else $error("switch drive did not follow write");

   a_boost_gate: assert property (
      conv.low_cell_threshold != `BBC_THR_ALWAYS && $past(below_ok)
      && !$past(wr_sw) |-> !conv.boost_allowed)
      else $error("boost allowed below cut-off");

   a_core_follow: assert property (
      wr_lv && wr_be[1] |-> ##2
      conv.core_rail_setpoint == $past(wr_data[`BBC_CORE_LSB +: 4], 2))
      else $error("core setpoint did not follow write");

   a_high_force: assert property (
      otp_on && !wr_lv |=> conv.high_rail_setpoint[2])
      else $error("high rail msb not forced");

   a_high_plain: assert property (
      !otp_on && !wr_lv |=>
      conv.high_rail_setpoint == $past(lv_r[`BBC_HIGH_LSB +: 3]))
      else $error("high rail setpoint altered");

   a_limit_follow: assert property (
      wr_lv && wr_be[0] && wr_be[1] |-> ##2
      conv.switch_current_limit == $past(wr_data[`BBC_ILIM_LSB +: 4], 2))
      else $error("current limit did not follow write");

   a_cal_follow: assert property (
      wr_lv && wr_be[0] |-> ##2
      conv.auto_calibration_ctrl == $past(wr_data[`BBC_CAL_LSB +: 3], 2))
      else $error("calibration field did not follow write");

   a_idle_sel: assert property (
      wr_id && wr_be[0] ##1 osc_ok |=>
      conv.idle_trigger == bbc_trig_t'({1'b0,
                           $past(wr_data[`BBC_IDLE_LSB +: 2], 2)}))
      else $error("idle trigger select wrong");

   a_idle_slow: assert property (
      !osc_ok |=> conv.idle_trigger == BBC_TRIG_32K)
      else $error("idle trigger not 32 kHz");

   a_step_down: assert property (
      conv.step_down_on == $past(id_r[`BBC_AUTO_BIT] && act_ok && gnd_ok))
      else $error("step-down enable wrong");

   a_hold_static: assert property (
      !wr_stb && !$past(wr_stb) && !$past(rst) && $stable(filt)
      && $past(filt) == $past(filt, 2) |=> $stable(conv))
      else $error("controls moved without cause");

   a_one_wait: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held beyond one cycle");

   a_battery_follow: assert property (
      wr_sw && wr_be[1] |-> ##2
      conv.battery_switch_drive == $past(wr_data[`BBC_PSW_LSB +: 2], 2))
      else $error("battery drive did not follow write");

   a_thr_follow: assert property (
      wr_sw && wr_be[0] |-> ##2
      conv.low_cell_threshold == $past(wr_data[`BBC_THR_LSB +: 3], 2))
      else $error("low cell threshold did not follow write");

   a_boost_open: assert property (
      conv.low_cell_threshold == `BBC_THR_ALWAYS |-> conv.boost_allowed)
      else $error("boost blocked with no cut-off");

   a_high_follow: assert property (
      wr_lv && wr_be[1] |-> ##2
      conv.high_rail_setpoint[1:0] == $past(wr_data[`BBC_HIGH_LSB +: 2], 2))
      else $error("high rail setpoint did not follow write");

   a_ton_follow: assert property (
      wr_lv && wr_be[0] && wr_be[1] |-> ##2
      conv.min_on_time == $past(wr_data[`BBC_TON_LSB +: 2], 2))
      else $error("min on-time did not follow write");

   a_timeout_follow: assert property (
      wr_id && wr_be[0] |-> ##2
      conv.idle_timeout == $past(wr_data[`BBC_TMO_LSB +: 2], 2))
      else $error("idle timeout did not follow write");

   a_read_zero: assert property (
      read && !waitrequest && hit == 3'h0 |-> readdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   a_read_upper: assert property (
      read && !waitrequest |-> readdata[31:16] == 16'h0000)
      else $error("upper read half not zero");

   c_write_switch: cover property (wr_sw ##2 conv.sense_trim != 2'h0);
   c_read_level: cover property (read && hit[1] && !waitrequest);
   c_force_msb: cover property (otp_on && !lv_r[`BBC_HIGH_LSB + 2]);
   c_osc_loss: cover property (osc_ok ##1 !osc_ok);

endmodule // bbc_regs

// >>> sim/bbc_conv_model.sv
// stand-in for the analogue converter stage and its status pins
// assumes the bench sets operating conditions at clock edges
module bbc_conv_model
   import bbc_pkg::*;
(
   // converter controls from the bank
   input  wire bbc_conv_t conv,
   // operating conditions chosen by the bench
   input  var  int        cell_mv,
   input  wire logic      osc_on,
   input  wire logic      reg_on,
   input  wire logic      active,
   input  wire logic      grounded,
   // status pins into the bank
   output logic           osc16_running,
   output logic           prog_mem_reg_en,
   output logic           device_active,
   output logic           low_cell_grounded,
   output logic           low_cell_below_cutoff
);
   timeunit 1ns;
   timeprecision 1ns;

   int cut_mv;

   // undefined codes treated as no cut-off, never below
   always_comb begin
      case (conv.low_cell_threshold)
         3'h6: cut_mv = 600;
         3'h5: cut_mv = 800;
         3'h3: cut_mv = 1000;
         default: cut_mv = 0;
      endcase
   end

   assign low_cell_below_cutoff = cell_mv < cut_mv;
   assign osc16_running         = osc_on;
   assign prog_mem_reg_en       = reg_on;
   assign device_active         = active;
   assign low_cell_grounded     = grounded;
endmodule // bbc_conv_model

// >>> sim/test_buck_boost_converter_config_regs.sv
// self-checking bench for the converter bank over avalon-mm
// assumes the bank answers every access; only the timeout ends a wait
`include "bbc_cfg.svh"

module test_buck_boost_converter_config_regs
   import bbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys, rst, read, write, waitrequest;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, q;
   logic [3:0]  byteenable;
   logic        osc16_running, prog_mem_reg_en, device_active;
   logic        low_cell_grounded, low_cell_below_cutoff;
   logic        osc_on, reg_on, active, grounded;
   bbc_conv_t   conv;
   int          cell_mv, errors, check_count, cycles;
   int          mdl [3];
   int          msk [3] = '{32'hFFFF, 32'hFFFF, 32'h001F};
   logic [7:0]  adr [4] = '{`BBC_DEC_SWITCH, `BBC_DEC_LEVEL, `BBC_DEC_IDLE,
                            8'h86};
   logic [3:0]  v;

   bbc_regs dut_u (.clk_sys(clk_sys), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .osc16_running(osc16_running),
      .prog_mem_reg_en(prog_mem_reg_en), .device_active(device_active),
      .low_cell_grounded(low_cell_grounded),
      .low_cell_below_cutoff(low_cell_below_cutoff), .conv(conv));

   bbc_conv_model stage_u (.conv(conv), .cell_mv(cell_mv), .osc_on(osc_on),
      .reg_on(reg_on), .active(active), .grounded(grounded),
      .osc16_running(osc16_running), .prog_mem_reg_en(prog_mem_reg_en),
      .device_active(device_active), .low_cell_grounded(low_cell_grounded),
      .low_cell_below_cutoff(low_cell_below_cutoff));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // whole run needs about a thousand cycles
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // index 3 is an unmapped word address
   task automatic bus(input logic wr, input int i, input logic [15:0] d,
                      input logic [3:0] be);
      @(posedge clk_sys);
      read       <= ~wr;
      write      <= wr;
      address    <= adr[i];
      writedata  <= {16'($urandom), d};
      byteenable <= be;
      // read right at the edge, before that edge's updates land
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (wr && i < 3) begin
         if (be[0]) mdl[i][7:0] = d[7:0];
         if (be[1]) mdl[i][15:8] = d[15:8];
         mdl[i] = mdl[i] & msk[i];
      end
   endtask

   task automatic rd_chk(input int i);
      bus(1'b0, i, 16'h0000, 4'hF);
      check(q, (i < 3) ? mdl[i] : 0);
   endtask

   function automatic bbc_conv_t exp_conv();
      bbc_conv_t   e;
      logic [15:0] s, l, d;
      int          cut;
      s = mdl[0][15:0];
      l = mdl[1][15:0];
      d = mdl[2][15:0];
      cut = (s[3:1] == 3'h6) ? 600 : (s[3:1] == 3'h5) ? 800 :
            (s[3:1] == 3'h3) ? 1000 : 0;
      e.sense_trim            = s[15:14];
      e.output_switch_drive   = bbc_drive_t'(s[13:12]);
      e.battery_switch_drive  = bbc_drive_t'(s[11:10]);
      e.ground_switch_drive   = bbc_drive_t'(s[9:8]);
      e.test_mode             = s[7:5];
      e.low_cell_threshold    = s[3:1];
      e.boost_allowed         = (s[3:1] == 3'h7) || (cell_mv >= cut);
      e.core_rail_setpoint    = l[15:12];
      e.high_rail_setpoint    = l[11:9] | {reg_on, 2'h0};
      e.min_on_time           = l[8:7];
      e.switch_current_limit  = l[6:3];
      e.auto_calibration_ctrl = l[2:0];
      e.idle_timeout          = d[4:3];
      e.idle_trigger = osc_on ? bbc_trig_t'({1'b0, d[2:1]}) : BBC_TRIG_32K;
      e.step_down_on          = d[0] & active & grounded;
      return e;
   endfunction

   // status pins pass a synchroniser, so allow ten edges
   task automatic settle();
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      check(conv, exp_conv());
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      mdl = '{32'h000C, 32'h8C20, 32'h0015};
   endtask

   initial begin
      void'($urandom(32'h07C5));
      {read, write, address, writedata, byteenable} = '0;
      {osc_on, active, reg_on, grounded} = 4'h8;
      {errors, check_count, cycles} = '0;
      cell_mv = 1500;
      rst = 1'b1;
      do_reset();
      for (int i = 0; i < 4; i++) rd_chk(i);
      settle();
      repeat (40) begin
         bus(1'b1, $urandom_range(3, 0), $urandom, $urandom);
         for (int i = 0; i < 4; i++) rd_chk(i);
      end
      v = mdl[1][15:12];
      bus(1'b1, 1, 16'h5000, 4'h2);
      @(negedge clk_sys);
      check(conv.core_rail_setpoint, v);
      @(negedge clk_sys);
      check(conv.core_rail_setpoint, 4'h5);
      // field codes and pin conditions swept together; covers 1 and 2
      for (int n = 0; n < 16; n++) begin
         v = n[3:0];
         @(posedge clk_sys);
         reg_on   <= v[0];
         osc_on   <= v[1];
         active   <= v[2];
         grounded <= v[3] | v[0];
         cell_mv  <= 500 + 200 * (n % 4);
         bus(1'b1, 0, {v[1:0], v[1:0], v[3:2], v[2:1], 4'h0, v[2:0], 1'b0},
             4'h3);
         // buck settings while the low cell is grounded, boost otherwise
         bus(1'b1, 1, {v, v[2:0], ((v[3] | v[0]) ? 2'h2 : 2'h1), v,
                       ((v[3] | v[0]) ? 3'h1 : 3'h6)}, 4'h3);
         bus(1'b1, 2, {11'h000, v[1:0], v[1:0], v[0]}, 4'h3);
         settle();
         rd_chk(1);
      end
      do_reset();
      for (int i = 0; i < 3; i++) rd_chk(i);
      report_and_stop();
   end
endmodule // test_buck_boost_converter_config_regs
